/* File: hw/pin_banks.sv */
// Two banks of four general-purpose pins behind an Avalon-MM register slave
//
// Behaviour
// - Upper nibble holds per-pin direction: 0 input, 1 output.
// - Data bit n pairs with direction bit n+4; direction changes only by write.
// - Reading an input pin's data bit returns its sampled present level.
// - Writing data of an input pin leaves it undriven, following outside level.
// - Output pin is driven to the last written data bit.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pin_bank_defs.svh"

module pin_banks #(
    parameter int PINS = `PB_PINS
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // Avalon-MM slave
    input  wire logic [`PB_ADDR_W-1:0]  avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [`PB_DATA_W-1:0]  avs_writedata,
    input  wire logic [`PB_BE_W-1:0]    avs_byteenable,
    output logic      [`PB_DATA_W-1:0]  avs_readdata,
    output logic                        avs_waitrequest,
    // Bank 0 pins
    input  wire logic [PINS-1:0]        bank0_pin_in,
    output logic      [PINS-1:0]        bank0_pin_out,
    output logic      [PINS-1:0]        bank0_pin_oe,
    // Bank 1 pins
    input  wire logic [PINS-1:0]        bank1_pin_in,
    output logic      [PINS-1:0]        bank1_pin_out,
    output logic      [PINS-1:0]        bank1_pin_oe
);

    import pin_bank_pkg::*;

    localparam int BANKS = 2;

    // Register layout packs direction and data nibbles into one byte
    generate
        if (PINS != `PB_PINS) begin : g_bad_pins
            $error("pin_banks PINS must equal the register nibble width");
        end
    endgenerate

    bus_state_t      bus_state;
    reg_sel_t        req_sel;
    logic            write_now;

    logic [PINS-1:0] dir      [BANKS];
    logic [PINS-1:0] data     [BANKS];
    logic [PINS-1:0] level    [BANKS];
    logic [PINS-1:0] pin_raw  [BANKS];

    // Address decode, shared by read path and write strobes
    function automatic reg_sel_t decode(input logic [`PB_ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if ((addr & `PB_ALIGN_MASK) == `PB_ALIGN_OK) begin
            unique case (addr)
                `PB_OFF_BANK0: sel = SEL_BANK0;
                `PB_OFF_BANK1: sel = SEL_BANK1;
                `PB_OFF_LEVEL: sel = SEL_LEVEL;
                `PB_OFF_LATCH: sel = SEL_LATCH;
                default:       sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Control register view: outputs echo the latch, inputs show the pin
    function automatic logic [`PB_REG_W-1:0] bank_view(
        input logic [PINS-1:0] d_dir,
        input logic [PINS-1:0] d_data,
        input logic [PINS-1:0] d_lvl
    );
        logic [`PB_REG_W-1:0] v;
        v = '0;
        v[`PB_DIR_HI:`PB_DIR_LO]   = d_dir;
        v[`PB_DATA_HI:`PB_DATA_LO] = (d_dir & d_data) | (~d_dir & d_lvl);
        return v;
    endfunction

    assign req_sel   = decode(avs_address);
    assign pin_raw[0] = bank0_pin_in;
    assign pin_raw[1] = bank1_pin_in;

    // Write lands on the edge where the master sees waitrequest low
    assign write_now = (bus_state == BUS_ANSWER) && avs_write
                       && avs_byteenable[`PB_BE_LANE];

    // Bus handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bus_state       <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state       <= BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ANSWER: begin
                    bus_state       <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read data captured one cycle ahead so it stands at the answer edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_readdata <= `PB_RDATA_RESET;
        end else if (bus_state == BUS_IDLE && avs_read) begin
            avs_readdata <= `PB_RDATA_RESET;
            unique case (req_sel)
                SEL_BANK0: avs_readdata[`PB_REG_W-1:0] <= bank_view(dir[0], data[0], level[0]);
                SEL_BANK1: avs_readdata[`PB_REG_W-1:0] <= bank_view(dir[1], data[1], level[1]);
                SEL_LEVEL: avs_readdata[`PB_REG_W-1:0] <= {level[1], level[0]};
                SEL_LATCH: avs_readdata[`PB_REG_W-1:0] <= {data[1], data[0]};
                SEL_NONE:  avs_readdata <= `PB_RDATA_RESET;
            endcase
        end
    end

    // Per-bank direction, data latch and synchroniser; pin drive is assigned after this block
    generate
        for (genvar b = 0; b < BANKS; b++) begin : g_bank
            localparam logic [PINS-1:0] DIR_RESET =
                (b == 0) ? `PB_DIR_RESET0 : `PB_DIR_RESET1;
            localparam reg_sel_t MY_SEL = (b == 0) ? SEL_BANK0 : SEL_BANK1;

            logic bank_hit;
            assign bank_hit = write_now && (req_sel == MY_SEL);

            // Pins are asynchronous to core_clk
            pin_sync #(
                .WIDTH (PINS)
            ) u_sync (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .async_in (pin_raw[b]),
                .sync_out (level[b])
            );

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    dir[b] <= DIR_RESET;
                end else if (bank_hit) begin
                    dir[b] <= avs_writedata[`PB_DIR_HI:`PB_DIR_LO];
                end
            end

            // Latch always stores, so a later switch to output drives it at once
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    data[b] <= `PB_DATA_RESET;
                end else if (bank_hit) begin
                    data[b] <= avs_writedata[`PB_DATA_HI:`PB_DATA_LO];
                end
            end
        end
    endgenerate

    // Enable follows direction; input pins stay undriven whatever the latch holds
    assign bank0_pin_oe  = dir[0];
    assign bank1_pin_oe  = dir[1];
    assign bank0_pin_out = data[0];
    assign bank1_pin_out = data[1];

endmodule

/* File: hw/pin_bank_defs.svh */
// Offsets, field positions and reset values of the pin bank registers
`ifndef PIN_BANK_DEFS_SVH
`define PIN_BANK_DEFS_SVH

`define PB_ADDR_W        4
`define PB_DATA_W        32
`define PB_BE_W          4

`define PB_OFF_BANK0     4'h0
`define PB_OFF_BANK1     4'h4
`define PB_OFF_LEVEL     4'h8
`define PB_OFF_LATCH     4'hC
`define PB_ALIGN_MASK    4'h3
`define PB_ALIGN_OK      4'h0

`define PB_DIR_HI        7
`define PB_DIR_LO        4
`define PB_DATA_HI       3
`define PB_DATA_LO       0
`define PB_REG_W         8
`define PB_BE_LANE       0

`define PB_DIR_RESET0    4'hF
`define PB_DIR_RESET1    4'h0
`define PB_DATA_RESET    4'h0
`define PB_SYNC_RESET    4'h0
`define PB_RDATA_RESET   32'h0000_0000
`define PB_PINS          4

`endif

/* File: hw/pin_bank_pkg.sv */
// Types shared by the pin bank design
package pin_bank_pkg;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

    typedef enum logic [2:0] {
        SEL_BANK0,
        SEL_BANK1,
        SEL_LEVEL,
        SEL_LATCH,
        SEL_NONE
    } reg_sel_t;

endpackage

/* File: hw/pin_sync.sv */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

/* File: verif/pin_board.sv */
// Board model: resolves each pin from the device drive and the outside level
`timescale 1ns/1ps
module pin_board (
    // Device side
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Outside level, seen while the device does not drive
    input  wire logic [3:0] ext_level,
    output logic      [3:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: verif/pin_banks_assertions.sv */
// Checker for the pin bank slave
`timescale 1ns/1ps
`include "pin_bank_defs.svh"
module pin_banks_assertions (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  bank0_pin_oe,
    input wire logic [3:0]  bank1_pin_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence wr_done(logic [3:0] a);
        avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
    endsequence
    sequence req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    bus_answer_a: assert property (req_taken |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    dir_write_a: assert property (
        wr_done(`PB_OFF_BANK0) |=> bank0_pin_oe == $past(avs_writedata[7:4]))
        else $error("direction not taken from write");
    data_write_a: assert property (
        wr_done(`PB_OFF_BANK1) |=> bank1_pin_out == $past(avs_writedata[3:0]))
        else $error("data latch not taken from write");
    dir_hold_a: assert property (
        bank0_pin_oe != $past(bank0_pin_oe)
        |-> $past(avs_write && !avs_waitrequest && avs_byteenable[0]
                  && avs_address == `PB_OFF_BANK0))
        else $error("direction changed without write");
    latch_hold_a: assert property (
        bank1_pin_out != $past(bank1_pin_out)
        |-> $past(avs_write && !avs_waitrequest && avs_byteenable[0]
                  && avs_address == `PB_OFF_BANK1))
        else $error("data latch changed without write");
endmodule
bind pin_banks pin_banks_assertions chk (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_waitrequest (avs_waitrequest),
    .bank0_pin_oe    (bank0_pin_oe),
    .bank1_pin_out   (bank1_pin_out)
);

/* File: verif/general_purpose_pin_banks_bench.sv */
// Bench for the two pin banks
`timescale 1ns/1ps
`include "pin_bank_defs.svh"
module general_purpose_pin_banks_bench;
    logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, ext0, ext1;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  bank0_pin_in, bank0_pin_out, bank0_pin_oe;
    logic [3:0]  bank1_pin_in, bank1_pin_out, bank1_pin_oe;
    logic [7:0]  q;
    logic [23:0] q_hi;
    int          mismatches, checks_done;
    pin_banks uut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .bank0_pin_in, .bank0_pin_out,
        .bank0_pin_oe, .bank1_pin_in, .bank1_pin_out, .bank1_pin_oe);
    pin_board b0 (.pin_out(bank0_pin_out), .pin_oe(bank0_pin_oe), .ext_level(ext0),
        .pin_in(bank0_pin_in));
    pin_board b1 (.pin_out(bank1_pin_out), .pin_oe(bank1_pin_oe), .ext_level(ext1),
        .pin_in(bank1_pin_in));
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic logic [7:0] ctrl(logic [3:0] d, logic [3:0] l, logic [3:0] e);
        return {d, (d & l) | (~d & e)};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= {3'h0, be};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata[7:0];
        q_hi = q_hi | avs_readdata[31:8];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
            print_verdict();
        end
    endtask
    task automatic reset_vals;
        bus(0, `PB_OFF_BANK0, 8'h00, 1);
        check("bank0 reset", 8'hF0, q);
        bus(0, `PB_OFF_BANK1, 8'h00, 1);
        check("bank1 input", ctrl(4'h0, 4'h0, ext1), q);
    endtask
    // Pin outputs are looked at one edge after the write lands
    task automatic input_keep;
        bus(1, `PB_OFF_BANK1, 8'h05, 1);
        @(posedge core_clk);
        check("bank1 oe", 8'h00, {4'h0, bank1_pin_oe});
        bus(0, `PB_OFF_BANK1, 8'h00, 1);
        check("bank1 follows pin", ctrl(4'h0, 4'h5, ext1), q);
        bus(0, `PB_OFF_LATCH, 8'h00, 1);
        check("latch kept", 8'h05, {4'h0, q[7:4]});
        bus(1, `PB_OFF_BANK1, 8'hF5, 1);
        @(posedge core_clk);
        check("bank1 drive", 8'hF5, {bank1_pin_oe, bank1_pin_out});
    endtask
    // Two extra edges let the new pin levels through the synchroniser
    task automatic mixed_dir;
        ext0 <= 4'h3;
        bus(1, `PB_OFF_BANK0, 8'h5A, 1);
        repeat (2) @(posedge core_clk);
        check("bank0 pins", 8'h5A, {bank0_pin_oe, bank0_pin_out});
        bus(0, `PB_OFF_BANK0, 8'h00, 1);
        check("bank0 mixed", ctrl(4'h5, 4'hA, 4'h3), q);
        check("bank0 oe", 8'h05, {4'h0, bank0_pin_oe});
    endtask
    task automatic refused;
        bus(1, 4'h2, 8'h00, 1);
        bus(1, `PB_OFF_BANK0, 8'h00, 0);
        bus(1, `PB_OFF_LATCH, 8'hFF, 1);
        bus(0, `PB_OFF_BANK0, 8'h00, 1);
        check("bank0 unchanged", ctrl(4'h5, 4'hA, 4'h3), q);
        bus(0, `PB_OFF_LATCH, 8'h00, 1);
        check("latch readback", 8'h5A, q);
        bus(0, `PB_OFF_LEVEL, 8'h00, 1);
        check("level readback", 8'h52, q);
        bus(0, 4'h2, 8'h00, 1);
        check("unmapped read", 8'h00, q);
        check("readdata upper", 8'h00, {7'h00, |q_hi});
    endtask
    initial begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        ext0 = 4'h0;
        ext1 = 4'hA;
        q_hi = '0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset_vals();
        input_keep();
        mixed_dir();
        refused();
        print_verdict();
    end
endmodule
